//--- logic/pla_pkg.sv
// Package with constants and carrier types for the link status and AER bank.
package pla_pkg;

   // ----------------------------------------------------------------------
   // Configuration address layout and fixed offsets
   // ----------------------------------------------------------------------
   localparam int unsigned ADDR_RSVD_HI = 31; // Top of the reserved nibble.
   localparam int unsigned ADDR_RSVD_LO = 28;
   localparam int unsigned ADDR_EXT_HI = 27; // Bits 27:24, unused; the bank takes the extended offset from bits 11:8.
   localparam int unsigned ADDR_EXT_LO = 24;
   localparam int unsigned ADDR_OFF_HI = 11; // Offset within one function.
   localparam logic [11:0] LINK_DW_ADDR = 12'h0F0; // Dword holding 0xF2.
   localparam logic [11:0] LINK_STATUS_ADDR = 12'h0F2;
   localparam logic [11:0] AER_BASE = 12'h100;
   localparam logic [11:0] SERIAL_BASE = 12'h140;
   localparam logic [11:0] NEXT_NONE = 12'h000;

   // Offsets inside the error reporting capability.
   localparam logic [11:0] AER_HDR_OFF = 12'h000;
   localparam logic [11:0] AER_UFLAG_OFF = 12'h004;
   localparam logic [11:0] AER_UMASK_OFF = 12'h008;
   localparam logic [11:0] AER_USEV_OFF = 12'h00C;
   localparam logic [11:0] AER_CFLAG_OFF = 12'h010;
   localparam logic [11:0] AER_CMASK_OFF = 12'h014;
   localparam logic [11:0] AER_FIRST_OFF = 12'h018;
   localparam logic [11:0] AER_LOG0_OFF = 12'h01C;
   localparam logic [11:0] AER_LOG3_OFF = 12'h028;

   // ----------------------------------------------------------------------
   // Field values
   // ----------------------------------------------------------------------
   localparam logic [3:0] LINK_SPEED_2G5 = 4'h1;
   localparam logic [5:0] LINK_WIDTH_X1 = 6'h01;
   localparam logic [2:0] LINK_RSVD = 3'h0;
   localparam logic [15:0] AER_CAP_ID = 16'h0001;
   localparam logic [3:0] AER_CAP_VER = 4'h1;

   // Implemented bits and reset values of the error registers.
   localparam logic [31:0] UNC_IMPL = 32'h0017F010;
   localparam logic [31:0] UNC_MASK_RST = 32'h00000000;
   localparam logic [31:0] UNC_SEV_RST = 32'h00062010;
   localparam logic [31:0] COR_IMPL = 32'h000031C1;
   localparam logic [31:0] COR_MASK_RST = 32'h00002000;
   localparam logic [31:0] FLAGS_RST = 32'h00000000;
   localparam logic [4:0] FIRST_RST = 5'h00;
   localparam logic [127:0] LOG_RST = 128'h0;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } pla_cfg_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } pla_cfg_rsp_t;

   typedef struct packed {
      logic correctable;
      logic nonfatal;
      logic fatal;
   } pla_err_msg_t;

endpackage

//--- logic/pla_cfg_bank.sv
// Configuration bank: link status register and the AER extended capability.
//
// Behaviour
// - Link status bits 3:0 report speed code 0001b, meaning 2.5 Gb/s.
// - Link status bits 9:4 report width code 000001b, a single lane.
// - Bit 10 latches a link training error; it clears only on reset.
// - Bit 11 follows the training input, registered one cycle late.
// - Bit 12 is loaded from the nonvolatile slot clock setting.
// - Link status is read-only; configuration writes change nothing.
// - Address bits 11:8 extend the decoded space to 4096 bytes.
// - Address bits 31:28 are reserved zero; nothing beyond 4096 decodes.
// - The first extended capability sits at offset 0x100.
// - Each capability header gives type, version and next pointer.
// - Error reporting at 0x100; no serial number capability is decoded, 0x140 reads zero.
// - Header bits 15:0 read the fixed error reporting capability ID.
// - Header bits 19:16 read the fixed capability version.
// - Header bits 31:20 read 0x140 when serial enabled, else zero.
// - Uncorrectable flags at 0x04 show each uncorrectable error source.
// - Uncorrectable mask at 0x08 suppresses error messages per source.
// - Uncorrectable severity at 0x0C selects fatal reporting per source.
// - Correctable flags at 0x10 show each correctable error source.
// - Correctable mask at 0x14 suppresses error messages per source.
// - Register 0x18 gives the bit position of the first uncorrectable error.
// - Registers 0x1C to 0x28 hold the header of the failing transaction.
// - Writing one clears a flag bit; other flag bits stay unchanged.
`timescale 1ns/100ps
module pla_cfg_bank (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire pla_pkg::pla_cfg_req_t cfg_req_i,
   output pla_pkg::pla_cfg_rsp_t cfg_rsp_o,
   input wire logic train_err_i,
   input wire logic training_i,
   input wire logic nvm_slot_clk_i,
   input wire logic nvm_serial_en_i,
   input wire logic [31:0] unc_err_i,
   input wire logic [31:0] cor_err_i,
   input wire logic [127:0] err_hdr_i,
   output pla_pkg::pla_err_msg_t err_msg_o
);

   // ----------------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------------
   logic addr_ok;
   logic [11:0] off;
   logic rd;
   logic wr;
   logic [31:0] bmask;

   // The offset is bits 11:0; bits 11:8 are its upper nibble in the
   // extended scheme, so 4096 bytes decode. Bus, device and function are
   // routing fields resolved upstream. A set reserved bit or a misaligned
   // dword makes the access unmapped: reads return zero, writes are lost.
   localparam int unsigned ADDR_EXT_HI_L = pla_pkg::ADDR_OFF_HI;
   localparam int unsigned ADDR_EXT_LO_L = 8;
   assign off = {cfg_req_i.addr[ADDR_EXT_HI_L:ADDR_EXT_LO_L],
                 cfg_req_i.addr[7:0]};
   assign addr_ok = (cfg_req_i.addr[pla_pkg::ADDR_RSVD_HI:
                                    pla_pkg::ADDR_RSVD_LO] == 4'h0)
                    && (cfg_req_i.addr[1:0] == 2'h0);
   assign rd = cfg_req_i.valid && !cfg_req_i.write && addr_ok;
   assign wr = cfg_req_i.valid && cfg_req_i.write && addr_ok;
   assign bmask = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}},
                   {8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};

   // ----------------------------------------------------------------------
   // Link status state
   // ----------------------------------------------------------------------
   logic init_done_q, init_done_d;
   logic slot_clk_q, slot_clk_d;
   logic serial_en_q, serial_en_d;
   logic link_err_q, link_err_d;
   logic training_q, training_d;
   logic [15:0] link_status;

   // Nonvolatile settings are caught once, on the first edge after reset is
   // released, because a flop under reset may only load a constant.
   always_comb begin
      init_done_d = 1'b1;
      slot_clk_d = init_done_q ? slot_clk_q : nvm_slot_clk_i;
      serial_en_d = init_done_q ? serial_en_q : nvm_serial_en_i;
      link_err_d = link_err_q | train_err_i;
      training_d = training_i;
   end

   // No configuration write reaches these flops; the register is read-only.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         init_done_q <= 1'b0;
         slot_clk_q <= 1'b0;
         serial_en_q <= 1'b0;
         link_err_q <= 1'b0;
         training_q <= 1'b0;
      end else begin
         init_done_q <= init_done_d;
         slot_clk_q <= slot_clk_d;
         serial_en_q <= serial_en_d;
         link_err_q <= link_err_d;
         training_q <= training_d;
      end
   end

   // Constant fields and live bits assembled into the 16-bit register.
   assign link_status = {pla_pkg::LINK_RSVD,
                         slot_clk_q, training_q, link_err_q,
                         pla_pkg::LINK_WIDTH_X1,
                         pla_pkg::LINK_SPEED_2G5};

   // ----------------------------------------------------------------------
   // Error reporting registers
   // ----------------------------------------------------------------------
   localparam logic [11:0] A_HDR =
      pla_pkg::AER_BASE + pla_pkg::AER_HDR_OFF;
   localparam logic [11:0] A_UFLAG =
      pla_pkg::AER_BASE + pla_pkg::AER_UFLAG_OFF;
   localparam logic [11:0] A_UMASK =
      pla_pkg::AER_BASE + pla_pkg::AER_UMASK_OFF;
   localparam logic [11:0] A_USEV =
      pla_pkg::AER_BASE + pla_pkg::AER_USEV_OFF;
   localparam logic [11:0] A_CFLAG =
      pla_pkg::AER_BASE + pla_pkg::AER_CFLAG_OFF;
   localparam logic [11:0] A_CMASK =
      pla_pkg::AER_BASE + pla_pkg::AER_CMASK_OFF;
   localparam logic [11:0] A_FIRST =
      pla_pkg::AER_BASE + pla_pkg::AER_FIRST_OFF;
   localparam logic [11:0] A_LOG0 =
      pla_pkg::AER_BASE + pla_pkg::AER_LOG0_OFF;
   localparam logic [11:0] A_LOG3 =
      pla_pkg::AER_BASE + pla_pkg::AER_LOG3_OFF;

   logic [31:0] uflag_q, uflag_d;
   logic [31:0] umask_q, umask_d;
   logic [31:0] usev_q, usev_d;
   logic [31:0] cflag_q, cflag_d;
   logic [31:0] cmask_q, cmask_d;
   logic [4:0] first_q, first_d;
   logic first_vld_q, first_vld_d;
   logic [127:0] log_q, log_d;
   logic [31:0] uset;
   logic [31:0] cset;
   logic [31:0] uclr;
   logic [31:0] cclr;
   pla_pkg::pla_err_msg_t msg_d;
   pla_pkg::pla_err_msg_t msg_q;

   assign uset = unc_err_i & pla_pkg::UNC_IMPL;
   assign cset = cor_err_i & pla_pkg::COR_IMPL;
   assign uclr = (wr && off == A_UFLAG) ? (cfg_req_i.wdata & bmask) : 32'h0;
   assign cclr = (wr && off == A_CFLAG) ? (cfg_req_i.wdata & bmask) : 32'h0;

   // Each flag bit: a new event wins over a clear landing in the same cycle,
   // so an error is never lost to a racing software clear.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_flag
         assign uflag_d[gi] = uset[gi]
            | (uflag_q[gi] & ~uclr[gi]);
         assign cflag_d[gi] = cset[gi]
            | (cflag_q[gi] & ~cclr[gi]);
      end
   endgenerate

   // Masks, severity, first error pointer, header log and messages.
   always_comb begin
      umask_d = umask_q;
      usev_d = usev_q;
      cmask_d = cmask_q;
      first_d = first_q;
      first_vld_d = first_vld_q;
      log_d = log_q;
      if (wr && off == A_UMASK) begin
         umask_d = ((umask_q & ~bmask) | (cfg_req_i.wdata & bmask))
                   & pla_pkg::UNC_IMPL;
      end
      if (wr && off == A_USEV) begin
         usev_d = ((usev_q & ~bmask) | (cfg_req_i.wdata & bmask))
                  & pla_pkg::UNC_IMPL;
      end
      if (wr && off == A_CMASK) begin
         cmask_d = ((cmask_q & ~bmask) | (cfg_req_i.wdata & bmask))
                   & pla_pkg::COR_IMPL;
      end
      // The pointer is released once software clears the bit it names.
      if (first_vld_q && !uflag_d[first_q]) begin
         first_vld_d = 1'b0;
      end
      // The lowest numbered new error wins a tie; the log follows it.
      if (!first_vld_q && uset != 32'h0) begin
         first_vld_d = 1'b1;
         log_d = err_hdr_i;
         for (int i = 31; i >= 0; i--) begin
            if (uset[i]) begin
               first_d = 5'(i);
            end
         end
      end
      msg_d.fatal = |(uset & ~umask_q & usev_q);
      msg_d.nonfatal = |(uset & ~umask_q & ~usev_q);
      msg_d.correctable = |(cset & ~cmask_q);
   end

   // Register the error bank.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         uflag_q <= pla_pkg::FLAGS_RST;
         umask_q <= pla_pkg::UNC_MASK_RST;
         usev_q <= pla_pkg::UNC_SEV_RST;
         cflag_q <= pla_pkg::FLAGS_RST;
         cmask_q <= pla_pkg::COR_MASK_RST;
         first_q <= pla_pkg::FIRST_RST;
         first_vld_q <= 1'b0;
         log_q <= pla_pkg::LOG_RST;
         msg_q <= '0;
      end else begin
         uflag_q <= uflag_d;
         umask_q <= umask_d;
         usev_q <= usev_d;
         cflag_q <= cflag_d;
         cmask_q <= cmask_d;
         first_q <= first_d;
         first_vld_q <= first_vld_d;
         log_q <= log_d;
         msg_q <= msg_d;
      end
   end

   assign err_msg_o = msg_q;

   // ----------------------------------------------------------------------
   // Read mux and response
   // ----------------------------------------------------------------------
   logic [11:0] next_ptr;
   pla_pkg::pla_cfg_rsp_t rsp_q, rsp_d;

   assign next_ptr = serial_en_q ? pla_pkg::SERIAL_BASE
                                 : pla_pkg::NEXT_NONE;

   // Every taken request is answered one cycle later; unmapped reads give 0.
   always_comb begin
      rsp_d.ack = cfg_req_i.valid;
      rsp_d.rdata = 32'h0;
      if (rd) begin
         case (off)
            pla_pkg::LINK_DW_ADDR: rsp_d.rdata = {link_status, 16'h0};
            A_HDR: rsp_d.rdata = {next_ptr, pla_pkg::AER_CAP_VER,
                                  pla_pkg::AER_CAP_ID};
            A_UFLAG: rsp_d.rdata = uflag_q;
            A_UMASK: rsp_d.rdata = umask_q;
            A_USEV: rsp_d.rdata = usev_q;
            A_CFLAG: rsp_d.rdata = cflag_q;
            A_CMASK: rsp_d.rdata = cmask_q;
            A_FIRST: rsp_d.rdata = {27'h0, first_q};
            A_LOG0: rsp_d.rdata = log_q[31:0];
            A_LOG0 + 12'h004: rsp_d.rdata = log_q[63:32];
            A_LOG0 + 12'h008: rsp_d.rdata = log_q[95:64];
            A_LOG3: rsp_d.rdata = log_q[127:96];
            default: rsp_d.rdata = 32'h0;
         endcase
      end
   end

   // Register the answer so that read data leaves from flops.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign cfg_rsp_o = rsp_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_link_const;
      @(posedge clk_i) disable iff (reset_i)
      (rd && off == pla_pkg::LINK_DW_ADDR) |=>
         cfg_rsp_o.ack && cfg_rsp_o.rdata[19:16] == 4'h1
         && cfg_rsp_o.rdata[25:20] == 6'h01;
   endproperty
   a_link_const: assert property (p_link_const)
      else $error("Link speed or width field wrong.");

   property p_train_err;
      @(posedge clk_i) disable iff (reset_i)
      train_err_i |=> link_err_q [*3];
   endproperty
   a_train_err: assert property (p_train_err)
      else $error("Training error bit not held.");

   // Reset must clear the sticky bit, so no disable clause here.
   property p_err_reset;
      @(posedge clk_i) reset_i |=> !link_err_q;
   endproperty
   a_err_reset: assert property (p_err_reset)
      else $error("Training error bit survived reset.");

   property p_training;
      @(posedge clk_i) disable iff (reset_i)
      ##1 link_status[11] == $past(training_i);
   endproperty
   a_training: assert property (p_training)
      else $error("Training bit does not follow training state.");

   property p_slot;
      @(posedge clk_i) disable iff (reset_i)
      $rose(init_done_q) |-> slot_clk_q == $past(nvm_slot_clk_i)
         ##1 $stable(slot_clk_q);
   endproperty
   a_slot: assert property (p_slot)
      else $error("Slot clock bit not loaded from setting.");

   property p_link_ro;
      @(posedge clk_i) disable iff (reset_i)
      (wr && off == pla_pkg::LINK_DW_ADDR && !train_err_i) |=>
         $stable(link_err_q) && link_status[15:13] == 3'h0;
   endproperty
   a_link_ro: assert property (p_link_ro)
      else $error("Write altered the link status register.");

   property p_rsvd_addr;
      @(posedge clk_i) disable iff (reset_i)
      (cfg_req_i.valid && cfg_req_i.addr[31:28] != 4'h0) |=>
         cfg_rsp_o.ack && cfg_rsp_o.rdata == 32'h0;
   endproperty
   a_rsvd_addr: assert property (p_rsvd_addr)
      else $error("Access above 4096 bytes was decoded.");

   property p_cap_hdr;
      @(posedge clk_i) disable iff (reset_i)
      (rd && off == pla_pkg::AER_BASE) |=>
         cfg_rsp_o.rdata[19:0] == 20'h10001
         && cfg_rsp_o.rdata[31:20] == (serial_en_q ? 12'h140 : 12'h000);
   endproperty
   a_cap_hdr: assert property (p_cap_hdr)
      else $error("Capability header reads wrong.");

   property p_w1c;
      @(posedge clk_i) disable iff (reset_i)
      (uclr[12] && !uset[12]) |=> !uflag_q[12];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("Write of one did not clear the flag.");

   property p_set_wins;
      @(posedge clk_i) disable iff (reset_i)
      uset[4] |=> uflag_q[4];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Uncorrectable event lost.");

   property p_msg;
      @(posedge clk_i) disable iff (reset_i)
      (uset[4] && !umask_q[4]) |=>
         ($past(usev_q[4]) ? err_msg_o.fatal : err_msg_o.nonfatal);
   endproperty
   a_msg: assert property (p_msg)
      else $error("Unmasked error sent no message.");

   // A full-width mask write lands, cut to the implemented sources.
   property p_umask_wr;
      @(posedge clk_i) disable iff (reset_i)
      (wr && off == A_UMASK && cfg_req_i.be == 4'hF) |=>
         umask_q == ($past(cfg_req_i.wdata) & pla_pkg::UNC_IMPL);
   endproperty
   a_umask_wr: assert property (p_umask_wr)
      else $error("Mask write did not land.");

   property p_first;
      @(posedge clk_i) disable iff (reset_i)
      (!first_vld_q && uset[12] && uset[11:0] == 12'h000) |=> first_vld_q
         && first_q == 5'h0C;
   endproperty
   a_first: assert property (p_first)
      else $error("First error pointer not recorded.");

endmodule

//--- testbench/pla_rc_model.sv
// Root complex model that issues configuration requests to the bank.
`timescale 1ns/100ps
module pla_rc_model (
   input wire logic clk_i,
   input wire pla_pkg::pla_cfg_rsp_t rsp_i,
   output pla_pkg::pla_cfg_req_t req_o
);
   // Bus, device and function fields placed above the register offset.
   logic [15:0] bdf = 16'h0000;
   int bad = 0;

   // ---------------------------------------------------------------
   // Request driver
   // ---------------------------------------------------------------
   // Idle fields carry inverted values, so a stale address never helps.
   initial req_o = '{1'b0, 1'b0, 32'hFFFFFFFF, 4'h0, 32'hFFFFFFFF};

   // One strobe cycle per request; the answer is taken one cycle later.
   task automatic cfg(input logic w, input logic [3:0] rsv,
      input logic [11:0] off, input logic [31:0] wd,
      output logic [31:0] rd);
      @(negedge clk_i);
      req_o.valid = 1'b1;
      req_o.write = w;
      req_o.addr = {rsv, bdf, off};
      req_o.be = 4'hF;
      req_o.wdata = wd;
      @(negedge clk_i);
      rd = rsp_i.rdata;
      if (rsp_i.ack !== 1'b1) bad++;
      req_o = '{1'b0, 1'b0, ~req_o.addr, 4'h0, ~wd};
   endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the link status and error reporting bank.
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic train_err_i = 1'b0;
   logic training_i = 1'b0;
   logic nvm_slot_clk_i = 1'b1;
   logic nvm_serial_en_i = 1'b1;
   logic [31:0] unc_err_i = 32'h00000000;
   logic [31:0] cor_err_i = 32'h00000000;
   logic [127:0] err_hdr_i = 128'h0;
   pla_pkg::pla_cfg_req_t cfg_req;
   pla_pkg::pla_cfg_rsp_t cfg_rsp;
   pla_pkg::pla_err_msg_t err_msg;
   int err_count = 0;
   int checked = 0;
   logic [31:0] lf = 32'h0000003A;
   logic [31:0] d, r, uf, cf, um, us, cm;
   logic [127:0] hdr;

   // Free-running core clock.
   always #2.5 clk_i = ~clk_i;

   pla_cfg_bank u_dut (.clk_i(clk_i), .reset_i(reset_i),
      .cfg_req_i(cfg_req), .cfg_rsp_o(cfg_rsp),
      .train_err_i(train_err_i), .training_i(training_i),
      .nvm_slot_clk_i(nvm_slot_clk_i), .nvm_serial_en_i(nvm_serial_en_i),
      .unc_err_i(unc_err_i), .cor_err_i(cor_err_i),
      .err_hdr_i(err_hdr_i), .err_msg_o(err_msg));
   pla_rc_model u_rc (.clk_i(clk_i), .rsp_i(cfg_rsp), .req_o(cfg_req));

   // ---------------------------------------------------------------
   // Expectations
   // ---------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] hdr_exp(input logic ser);
      return {ser ? pla_pkg::SERIAL_BASE : pla_pkg::NEXT_NONE,
         pla_pkg::AER_CAP_VER, pla_pkg::AER_CAP_ID};
   endfunction
   // Link status sits in the upper half of its dword.
   function automatic logic [31:0] lnk_exp(input logic sl, te, tr);
      return {pla_pkg::LINK_RSVD, sl, tr, te, pla_pkg::LINK_WIDTH_X1,
         pla_pkg::LINK_SPEED_2G5, 16'h0000};
   endfunction
   function automatic logic [31:0] def_exp(input int i, input logic ser);
      case (i)
         0: return hdr_exp(ser);
         3: return pla_pkg::UNC_SEV_RST;
         5: return pla_pkg::COR_MASK_RST;
         default: return 32'h00000000;
      endcase
   endfunction
   function automatic logic [2:0] msg_exp(input logic [31:0] u, c);
      logic [31:0] v;
      v = u & ~um & pla_pkg::UNC_IMPL;
      return {|(c & ~cm & pla_pkg::COR_IMPL), |(v & ~us), |(v & us)};
   endfunction

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] off, input logic [31:0] v);
      u_rc.cfg(1'b1, 4'h0, off, v, r);
      chk(r, 32'h00000000, "write data");
   endtask
   task automatic rd(input logic [11:0] off, input logic [31:0] e);
      u_rc.cfg(1'b0, 4'h0, off, 32'h00000000, r);
      chk(r, e, "read data");
   endtask
   // The slot clock and serial settings are captured just after release.
   task automatic do_reset(input logic sl, ser);
      @(negedge clk_i);
      reset_i = 1'b1;
      nvm_slot_clk_i = sl;
      nvm_serial_en_i = ser;
      repeat (5) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (2) @(negedge clk_i);
      um = pla_pkg::UNC_MASK_RST;
      us = pla_pkg::UNC_SEV_RST;
      cm = pla_pkg::COR_MASK_RST;
      uf = 32'h00000000;
      cf = 32'h00000000;
   endtask
   // One event cycle; the message pulse is looked at in the next cycle.
   task automatic ev(input logic [31:0] u, c);
      @(negedge clk_i);
      unc_err_i = u;
      cor_err_i = c;
      @(negedge clk_i);
      unc_err_i = 32'h00000000;
      cor_err_i = 32'h00000000;
      chk(32'(err_msg), 32'(msg_exp(u, c)), "message");
      uf = uf | (u & pla_pkg::UNC_IMPL);
      cf = cf | (c & pla_pkg::COR_IMPL);
   endtask
   task automatic end_of_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   // Two reset passes so both nonvolatile settings are seen.
   initial begin
      for (int k = 0; k < 2; k++) begin
         do_reset(k == 0, k == 0);
         rd(12'h0F0, lnk_exp(k == 0, 1'b0, 1'b0));
         training_i = 1'b1;
         rd(12'h0F0, lnk_exp(k == 0, 1'b0, 1'b1));
         training_i = 1'b0;
         wr(pla_pkg::LINK_DW_ADDR, 32'hFFFFFFFF);
         for (int i = 0; i < 11; i++)
            if (i == 0 || i > 5) wr(12'h100 + 12'(4 * i), 32'hFFFFFFFF);
         rd(12'h0F0, lnk_exp(k == 0, 1'b0, 1'b0));
         for (int i = 0; i < 11; i++)
            rd(12'h100 + 12'(4 * i), def_exp(i, k == 0));
         train_err_i = 1'b1;
         @(negedge clk_i);
         train_err_i = 1'b0;
         rd(12'h0F0, lnk_exp(k == 0, 1'b1, 1'b0));
         $display("test status pass %0d done", k);
      end
      // Any bus, device and function select the same bank.
      lf = nxt(lf);
      u_rc.bdf = lf[15:0];
      rd(12'h100, hdr_exp(1'b0));
      rd(12'h000, 32'h00000000);
      u_rc.cfg(1'b0, 4'h1, 12'h100, 32'h00000000, r);
      chk(r, 32'h00000000, "reserved nibble");
      u_rc.cfg(1'b0, 4'h0, 12'h102, 32'h00000000, r);
      chk(r, 32'h00000000, "misaligned");
      $display("test decode done");
      // Two sources at once: the lower bit is the first error.
      hdr = {lf, nxt(lf), ~lf, lf ^ 32'hA5A5A5A5};
      err_hdr_i = hdr;
      ev(32'h00041000, 32'h00002001);
      ev(32'h00000000, 32'h00002000);
      ev(32'h00000010, 32'h00000000);
      rd(12'h118, 32'h0000000C);
      for (int i = 0; i < 4; i++)
         rd(12'h11C + 12'(4 * i), hdr[32 * i +: 32]);
      rd(12'h104, uf);
      rd(12'h110, cf);
      wr(12'h104, 32'h00001000);
      uf[12] = 1'b0;
      rd(12'h104, uf);
      $display("test first error done");
      // Random masks, severities, events and clears.
      for (int n = 0; n < 24; n++) begin
         if (n % 8 == 0) begin
            lf = nxt(lf);
            um = lf & pla_pkg::UNC_IMPL;
            wr(12'h108, lf);
            lf = nxt(lf);
            us = lf & pla_pkg::UNC_IMPL;
            wr(12'h10C, lf);
            lf = nxt(lf);
            cm = lf & pla_pkg::COR_IMPL;
            wr(12'h114, lf);
            rd(12'h108, um);
            rd(12'h10C, us);
            rd(12'h114, cm);
         end
         lf = nxt(lf);
         d = lf & nxt(lf);
         lf = nxt(nxt(lf));
         ev(d, lf & nxt(lf));
         rd(12'h104, uf);
         rd(12'h110, cf);
         lf = nxt(lf);
         wr(12'h104, lf);
         uf = uf & ~lf;
         wr(12'h110, lf);
         cf = cf & ~lf;
      end
      rd(12'h104, uf);
      $display("test random done");
      chk(32'(u_rc.bad), 32'h00000000, "missing ack");
      end_of_test();
   end

   // Watchdog well beyond the expected run of about four hundred cycles.
   initial begin
      #20000;
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
